/* tcms_checker.sv */
// assertion checker for the timer unit clock and mode setup block
`timescale 1ns/10ps
`default_nettype none
module tcms_checker
   import tcms_pkg::*;
(
   input wire logic        I_CLOCK,
   input wire logic        I_NRST,
   input wire logic        I_CE,
   input wire logic [3:0]  I_ADDR,
   input wire logic [15:0] I_WDATA,
   input wire logic        I_WR,
   input wire logic        I_RD,
   input wire logic [15:0] O_RDATA,
   input wire logic        O_UNIT_IN_RESET,
   input wire logic        O_UNIT_CLOCKED,
   input wire logic        O_COUNT_TICK,
   input wire logic        O_COUNT_UP,
   input wire logic        O_WIDTH_8BIT,
   input wire logic [2:0]  O_OP_MODE,
   input wire logic        O_MODE_PROHIBITED,
   input wire logic        O_START
);
   // ==========================================================
   // helper decode of accepted writes
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_NRST);
   wire w_any  = I_WR && I_CE;
   wire live   = O_UNIT_CLOCKED && !O_UNIT_IN_RESET;
   wire w_mode = w_any && I_ADDR == ADDR_CH0_MODE && live;
   // expected mode from the raw code; odd codes of event and capture+one are illegal
   function automatic logic [2:0] mode_of(input logic [3:0] c);
      case (c[3:1])
         3'h0: return 3'h0;
         3'h2: return 3'h1;
         3'h3: return c[0] ? 3'h5 : 3'h2;
         3'h4: return 3'h3;
         3'h6: return c[0] ? 3'h5 : 3'h4;
         default: return 3'h5;
      endcase
   endfunction
   // ==========================================================
   // assertions
   AST_RD_IDLE: assert property (I_CE && !I_RD |=> O_RDATA == 16'h0000)
      else $error("read data not zero after idle cycle");
   AST_RESET_BIT: assert property (w_any && I_ADDR == ADDR_RESET_CTRL |=> O_UNIT_IN_RESET == $past(I_WDATA[0]))
      else $error("unit reset level does not follow write");
   AST_CLOCK_BIT: assert property (w_any && I_ADDR == ADDR_CLOCK_EN |=> O_UNIT_CLOCKED == $past(I_WDATA[0]))
      else $error("unit clock level does not follow write");
   AST_RESET_HOLD: assert property (O_UNIT_IN_RESET && $past(O_UNIT_IN_RESET)
      |-> !O_COUNT_TICK && O_OP_MODE == 3'h0 && !O_WIDTH_8BIT)
      else $error("channel active while unit held in reset");
   AST_WIDTH: assert property (w_mode |=> O_WIDTH_8BIT == $past(I_WDATA[11]))
      else $error("width select does not follow bit 11");
   AST_MODE: assert property (w_mode |=> O_OP_MODE == mode_of($past(I_WDATA[3:0])))
      else $error("mode decode wrong");
   AST_PROHIB: assert property (O_MODE_PROHIBITED == (O_OP_MODE == 3'h5))
      else $error("prohibited flag disagrees with mode");
   AST_COUNT_UP: assert property (O_COUNT_UP == (O_OP_MODE inside {3'h1, 3'h4}))
      else $error("count direction wrong for mode");
   AST_START: assert property (w_any && live && I_ADDR == ADDR_CH0_TRIGGER && I_WDATA[0] |=> O_START)
      else $error("software start gave no pulse");
   AST_REFUSED: assert property (w_any && I_ADDR == ADDR_CH0_MODE && !O_UNIT_CLOCKED && !O_UNIT_IN_RESET
      |=> $stable(O_OP_MODE) && $stable(O_WIDTH_8BIT))
      else $error("mode written while unit unclocked");
   // main scenarios seen
   COV_PROHIB: cover property (w_mode ##1 O_MODE_PROHIBITED);
   COV_TICK: cover property (O_COUNT_TICK);
   COV_START: cover property (O_START);
endmodule
bind tcms_top tcms_checker u_tcms_checker (.I_CLOCK, .I_NRST, .I_CE, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
   .O_RDATA, .O_UNIT_IN_RESET, .O_UNIT_CLOCKED, .O_COUNT_TICK, .O_COUNT_UP, .O_WIDTH_8BIT,
   .O_OP_MODE, .O_MODE_PROHIBITED, .O_START);
`default_nettype wire

/* tcms_edge_detect.sv */
// synchronised timer input pin with valid-edge pulse
`timescale 1ns/10ps
`default_nettype none
module tcms_edge_detect (
   input  wire logic            i_clk,
   input  wire logic            i_nrst,
   input  wire logic            i_ce,
   input  wire logic            i_pin,
   input  wire logic [1:0]      i_edge_sel,
   output logic                 o_level,
   output logic                 o_edge
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic       rise;
   logic       fall;

   // ==========================================================
   // two flops for metastability, third for edge history
   always_comb begin
      sync_next = {sync_reg[1:0], i_pin};
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync_reg <= 3'h0;
      end else if (i_ce) begin
         sync_reg <= sync_next;
      end
   end

   // only stages 1 and 2 are looked at, never stage 0
   assign rise    = sync_reg[1] && !sync_reg[2];
   assign fall    = !sync_reg[1] && sync_reg[2];
   assign o_level = sync_reg[1];
   assign o_edge  = i_ce && ((i_edge_sel == 2'h0) ? fall :
                             (i_edge_sel == 2'h1) ? rise : (rise || fall));
endmodule
`default_nettype wire

/* tcms_pkg.sv */
// shared constants for the timer unit clock and mode setup block
package tcms_pkg;
   // ==========================================================
   // register addresses (word index on the plain port)
   localparam logic [3:0]  ADDR_RESET_CTRL  = 4'h0;
   localparam logic [3:0]  ADDR_CLOCK_EN    = 4'h1;
   localparam logic [3:0]  ADDR_PRESCALER   = 4'h2;
   localparam logic [3:0]  ADDR_CH0_MODE    = 4'h3;
   localparam logic [3:0]  ADDR_CH0_STATUS  = 4'h4;
   localparam logic [3:0]  ADDR_CH0_TRIGGER = 4'h5;
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 16;
   // ==========================================================
   // reset values
   localparam logic [7:0]  RESET_CTRL_RST   = 8'h01;
   localparam logic [7:0]  CLOCK_EN_RST     = 8'h00;
   localparam logic [15:0] PRESCALER_RST    = 16'h0000;
   localparam logic [15:0] CH0_MODE_RST     = 16'h0000;
   // ==========================================================
   // field positions
   localparam int          UNIT_BIT         = 0;
   localparam int          PRS_FIRST_LSB    = 0;
   localparam int          PRS_SECOND_LSB   = 4;
   localparam int          PRS_THIRD_LSB    = 8;
   localparam int          PRS_FOURTH_LSB   = 12;
   localparam int          PRS_W            = 4;
   localparam int          CLK_PICK_LSB     = 14;
   localparam int          COUNT_SRC_BIT    = 12;
   localparam int          WIDTH8_BIT       = 11;
   localparam int          TRIG_LSB         = 8;
   localparam int          EDGE_LSB         = 6;
   localparam int          MODE_LSB         = 0;
   // writable bits of the channel mode register; others read zero
   localparam logic [15:0] CH0_MODE_MASK    = 16'hDFCF;
   // prescaler fields: bits 15,14,11,10 read zero
   localparam logic [15:0] PRESCALER_MASK   = 16'h33FF;
   // ==========================================================
   // enumerations
   typedef enum logic [1:0] {
      CLK_PICK_FIRST  = 2'h0,
      CLK_PICK_THIRD  = 2'h1,
      CLK_PICK_SECOND = 2'h2,
      CLK_PICK_FOURTH = 2'h3
   } tcms_clk_pick_t;
   typedef enum logic [1:0] {
      EDGE_FALL = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_BOTH_LOW = 2'h2,
      EDGE_BOTH_HIGH = 2'h3
   } tcms_edge_t;
   typedef enum logic [2:0] {
      OPM_INTERVAL,
      OPM_CAPTURE,
      OPM_EVENT,
      OPM_ONE_COUNT,
      OPM_CAPTURE_ONE,
      OPM_PROHIBITED
   } tcms_opmode_t;
endpackage

/* tcms_prescaler.sv */
// free-running divider giving one-cycle ticks at fclk / 2^n
`timescale 1ns/10ps
`default_nettype none
module tcms_prescaler #(
   parameter int DIV_W = 15
) (
   input  wire logic            i_clk,
   input  wire logic            i_nrst,
   input  wire logic            i_ce,
   input  wire logic            i_unit_rst,
   input  wire logic [3:0]      i_sel,
   output logic                 o_tick
);
   logic [DIV_W-1:0] cnt_reg;
   logic [DIV_W-1:0] cnt_next;
   logic [DIV_W-1:0] low_mask;

   // ==========================================================
   // divider: tick when the low sel bits are all ones
   always_comb begin
      cnt_next = cnt_reg + 1'b1;
      if (i_unit_rst) begin
         cnt_next = '0;
      end
      low_mask = DIV_W'((32'h1 << i_sel) - 32'h1);
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_reg <= '0;
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
      end
   end

   // sel 0 ticks every cycle, sel 15 every 32768 cycles
   assign o_tick = !i_unit_rst && ((cnt_reg & low_mask) == low_mask); // R03
endmodule
`default_nettype wire

/* tcms_top.sv */
// timer unit reset, clock gating, prescaler and channel 0 mode setup
// ==========================================================
// What this block does
// R01: reset bit 1 holds timer unit reset
// R02: enable bit 1 supplies unit clock
// R03: prescaler low nibble divides by 2^n
// R04: mode bits 15:14 pick operation clock
// R05: bit 12 selects prescaled clock or pin
// R06: bit 11 selects 16-bit or 8-bit
// R07: trigger, edge and mode fields stored
// R08: mode field decodes five modes, prohibited rest
// R09: trigger 000 allows only software start
// R10: software releases reset and clock first
`timescale 1ns/10ps
`default_nettype none
module tcms_top
   import tcms_pkg::*;
(
   input  wire logic                   I_CLOCK,
   input  wire logic                   I_NRST,
   input  wire logic                   I_CE,
   input  wire logic [tcms_pkg::ADDR_W-1:0] I_ADDR,
   input  wire logic [tcms_pkg::DATA_W-1:0] I_WDATA,
   input  wire logic                   I_WR,
   input  wire logic                   I_RD,
   input  wire logic                   I_TIMER_IN,
   output logic [tcms_pkg::DATA_W-1:0] O_RDATA,
   output logic                        O_UNIT_IN_RESET,
   output logic                        O_UNIT_CLOCKED,
   output logic                        O_COUNT_TICK,
   output logic                        O_COUNT_UP,
   output logic                        O_WIDTH_8BIT,
   output logic [2:0]                  O_OP_MODE,
   output logic                        O_MODE_PROHIBITED,
   output logic                        O_START
);
   import tcms_pkg::*;

   logic [7:0]        rst_ctrl_reg;
   logic [7:0]        rst_ctrl_next;
   logic [7:0]        clk_en_reg;
   logic [7:0]        clk_en_next;
   logic [15:0]       prs_reg;
   logic [15:0]       prs_next;
   logic [15:0]       mode_reg;
   logic [15:0]       mode_next;
   logic [15:0]       rdata_reg;
   logic [15:0]       rdata_next;
   logic              start_reg;
   logic              start_next;
   logic [3:0]        ticks;
   logic              unit_rst;
   logic              unit_ce;
   logic              regs_open;
   logic              pin_level;
   logic              pin_edge;
   logic              op_tick;
   logic              sw_trig;
   logic              hw_trig;
   tcms_clk_pick_t    clk_pick;
   tcms_opmode_t      opmode;

   // ==========================================================
   // unit reset and clock gate
   assign unit_rst  = rst_ctrl_reg[UNIT_BIT];               // R01
   assign unit_ce   = I_CE && clk_en_reg[UNIT_BIT];         // R02
   // unit registers only take writes while clocked and out of reset
   assign regs_open = clk_en_reg[UNIT_BIT] && !unit_rst;    // R10

   // ==========================================================
   // four prescaled clocks, one divider per selector nibble
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_prs
         tcms_prescaler #(
            .DIV_W (15)
         ) u_prs (
            .i_clk      (I_CLOCK),
            .i_nrst     (I_NRST),
            .i_ce       (unit_ce),
            .i_unit_rst (unit_rst),
            .i_sel      (prs_reg[g*PRS_W +: PRS_W]),
            .o_tick     (ticks[g])
         );
      end
   endgenerate

   // ==========================================================
   // timer input pin, synchronised before use
   tcms_edge_detect u_edge (
      .i_clk      (I_CLOCK),
      .i_nrst     (I_NRST),
      .i_ce       (unit_ce),
      .i_pin      (I_TIMER_IN),
      .i_edge_sel (mode_reg[EDGE_LSB +: 2]),
      .o_level    (pin_level),
      .o_edge     (pin_edge)
   );

   // ==========================================================
   // channel clock pick: note codes 01 and 10 are crossed
   always_comb begin
      clk_pick = tcms_clk_pick_t'(mode_reg[CLK_PICK_LSB +: 2]);
      case (clk_pick)
         CLK_PICK_FIRST:  op_tick = ticks[0];               // R04
         CLK_PICK_THIRD:  op_tick = ticks[2];               // R04
         CLK_PICK_SECOND: op_tick = ticks[1];               // R04
         default:         op_tick = ticks[3];               // R04
      endcase
   end

   // count clock: prescaled tick or pin valid edge
   assign O_COUNT_TICK = !unit_rst && unit_ce &&
                         (mode_reg[COUNT_SRC_BIT] ? pin_edge : op_tick); // R05
   assign O_WIDTH_8BIT = mode_reg[WIDTH8_BIT];              // R06

   // ==========================================================
   // operation mode decode; low bit is an option for interval, capture and one-count, prohibited for event and capture+one
   always_comb begin
      case (mode_reg[MODE_LSB +: 4])
         4'h0, 4'h1: opmode = OPM_INTERVAL;                 // R08
         4'h4, 4'h5: opmode = OPM_CAPTURE;                  // R08
         4'h6:       opmode = OPM_EVENT;                    // R08
         4'h8, 4'h9: opmode = OPM_ONE_COUNT;                // R08
         4'hC:       opmode = OPM_CAPTURE_ONE;              // R08
         default:    opmode = OPM_PROHIBITED;               // R08
      endcase
   end

   assign O_OP_MODE         = opmode;
   assign O_MODE_PROHIBITED = (opmode == OPM_PROHIBITED);
   // capture modes count up, the rest count down
   assign O_COUNT_UP        = (opmode == OPM_CAPTURE) || (opmode == OPM_CAPTURE_ONE);

   // ==========================================================
   // start trigger: software always; pin edges only for codes 001/010
   assign sw_trig = I_WR && (I_ADDR == ADDR_CH0_TRIGGER) && I_WDATA[0] && regs_open;
   always_comb begin
      case (mode_reg[TRIG_LSB +: 3])
         3'h0:    hw_trig = 1'b0;                           // R09
         3'h1:    hw_trig = pin_edge;
         3'h2:    hw_trig = pin_edge;
         default: hw_trig = 1'b0; // master interrupt not in this block
      endcase
   end

   // ==========================================================
   // register writes; the unit's own registers clear under unit reset
   always_comb begin
      rst_ctrl_next = rst_ctrl_reg;
      clk_en_next   = clk_en_reg;
      prs_next      = prs_reg;
      mode_next     = mode_reg;
      start_next    = 1'b0;
      if (I_WR && (I_ADDR == ADDR_RESET_CTRL)) begin
         rst_ctrl_next = {7'h00, I_WDATA[UNIT_BIT]};        // R01
      end else if (I_WR && (I_ADDR == ADDR_CLOCK_EN)) begin
         clk_en_next = {7'h00, I_WDATA[UNIT_BIT]};          // R02
      end else if (I_WR && (I_ADDR == ADDR_PRESCALER) && regs_open) begin
         prs_next = I_WDATA & PRESCALER_MASK;               // R03
      end else if (I_WR && (I_ADDR == ADDR_CH0_MODE) && regs_open) begin
         mode_next = I_WDATA & CH0_MODE_MASK;               // R07
      end
      if (!unit_rst) begin
         start_next = sw_trig || hw_trig;
      end
      if (unit_rst) begin
         prs_next  = PRESCALER_RST;                         // R01
         mode_next = CH0_MODE_RST;                          // R01
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         rst_ctrl_reg <= RESET_CTRL_RST;
         clk_en_reg   <= CLOCK_EN_RST;
         prs_reg      <= PRESCALER_RST;
         mode_reg     <= CH0_MODE_RST;
         start_reg    <= 1'b0;
      end else if (I_CE) begin
         rst_ctrl_reg <= rst_ctrl_next;
         clk_en_reg   <= clk_en_next;
         prs_reg      <= prs_next;
         mode_reg     <= mode_next;
         start_reg    <= start_next;
      end
   end

   // ==========================================================
   // read port: data valid the cycle after the strobe
   always_comb begin
      rdata_next = 16'h0000;
      if (I_RD) begin
         if (I_ADDR == ADDR_RESET_CTRL) begin
            rdata_next = {8'h00, rst_ctrl_reg};
         end else if (I_ADDR == ADDR_CLOCK_EN) begin
            rdata_next = {8'h00, clk_en_reg};
         end else if (I_ADDR == ADDR_PRESCALER) begin
            rdata_next = prs_reg;
         end else if (I_ADDR == ADDR_CH0_MODE) begin
            rdata_next = mode_reg;
         end else if (I_ADDR == ADDR_CH0_STATUS) begin
            rdata_next = {11'h000, pin_level, O_MODE_PROHIBITED, opmode};
         end else begin
            rdata_next = 16'h0000; // unmapped reads zero
         end
      end
   end

   always_ff @(posedge I_CLOCK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_reg <= 16'h0000;
      end else if (I_CE) begin
         rdata_reg <= rdata_next;
      end
   end

   assign O_RDATA         = rdata_reg;
   assign O_UNIT_IN_RESET = unit_rst;
   assign O_UNIT_CLOCKED  = clk_en_reg[UNIT_BIT];
   assign O_START         = start_reg;
endmodule
`default_nettype wire

/* tcms_top_tb_top.sv */
// self-checking bench for the timer unit clock and mode setup block
`timescale 1ns/10ps
`default_nettype none
module tcms_top_tb_top;
   import tcms_pkg::*;
   logic        i_clock = 1'b0;
   logic        i_nrst = 1'b0;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_pin = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000;
   logic [15:0] o_rdata;
   logic [2:0]  o_mode;
   logic        o_rst, o_clk_on, o_tick, o_up, o_w8, o_prohib, o_start;
   int          err_count = 0;
   int          samples_checked = 0;
   int          ticks, starts;
   // ==========================================================
   // clock and design
   always #50 i_clock = ~i_clock;
   tcms_top u_tcms_top (.I_CLOCK(i_clock), .I_NRST(i_nrst), .I_CE(1'b1), .I_ADDR(i_addr),
      .I_WDATA(i_wdata), .I_WR(i_wr), .I_RD(i_rd), .I_TIMER_IN(i_pin), .O_RDATA(o_rdata),
      .O_UNIT_IN_RESET(o_rst), .O_UNIT_CLOCKED(o_clk_on), .O_COUNT_TICK(o_tick), .O_COUNT_UP(o_up),
      .O_WIDTH_8BIT(o_w8), .O_OP_MODE(o_mode), .O_MODE_PROHIBITED(o_prohib), .O_START(o_start));
   // ==========================================================
   // shared tasks
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1;
      chk("rdata", o_rdata, e);
   endtask
   // counts ticks and starts; p toggles the pin every p cycles
   task automatic run(input int n, input int p);
      ticks = 0;
      starts = 0;
      for (int k = 0; k < n; k++) begin
         @(posedge i_clock);
         if (p != 0 && k % p == 0) i_pin <= ~i_pin;
         @(negedge i_clock);
         if (o_tick === 1'b1) ticks++;
         if (o_start === 1'b1) starts++;
      end
   endtask
   function automatic logic [2:0] exp_mode(input logic [3:0] c);
      case (c[3:1])
         3'h0: return 3'h0;
         3'h2: return 3'h1;
         3'h3: return c[0] ? 3'h5 : 3'h2;
         3'h4: return 3'h3;
         3'h6: return c[0] ? 3'h5 : 3'h4;
         default: return 3'h5;
      endcase
   endfunction
   // ==========================================================
   // scenarios
   task automatic t_reset_state();
      chk("in_reset", 16'(o_rst), 16'h0001);
      rd(ADDR_RESET_CTRL, 16'h0001);
      rd(ADDR_CLOCK_EN, 16'h0000);
      wr(ADDR_CH0_MODE, 16'h0801);
      rd(ADDR_CH0_MODE, 16'h0000);
      rd(4'hF, 16'h0000);
   endtask
   // clock on but still in reset: mode stays locked
   task automatic t_setup();
      wr(ADDR_CLOCK_EN, 16'h00FF);
      rd(ADDR_CLOCK_EN, 16'h0001);
      chk("clocked", 16'(o_clk_on), 16'h0001);
      wr(ADDR_CH0_MODE, 16'h0800);
      rd(ADDR_CH0_MODE, 16'h0000);
      wr(ADDR_RESET_CTRL, 16'h0000);
      // let the write edge settle before looking
      @(negedge i_clock);
      chk("in_reset", 16'(o_rst), 16'h0000);
      wr(ADDR_PRESCALER, 16'hFFFF);
      rd(ADDR_PRESCALER, 16'h33FF);
      wr(ADDR_CH0_MODE, 16'hFFFF);
      rd(ADDR_CH0_MODE, 16'hDFCF);
   endtask
   // every mode code, width bit alternating with the code
   task automatic t_modes();
      for (int c = 0; c < 16; c++) begin
         wr(ADDR_CH0_MODE, {4'h0, c[0], 7'h00, c[3:0]});
         @(negedge i_clock);
         chk("op_mode", 16'(o_mode), 16'(exp_mode(c[3:0])));
         chk("prohib", 16'(o_prohib), 16'(exp_mode(c[3:0]) == 3'h5));
         chk("count_up", 16'(o_up), 16'(exp_mode(c[3:0]) inside {3'h1, 3'h4}));
         chk("width8", 16'(o_w8), 16'(c[0]));
         rd(ADDR_CH0_STATUS, {11'h000, 1'b0, (exp_mode(c[3:0]) == 3'h5), exp_mode(c[3:0])});
      end
   endtask
   // picks 00,01,10,11 map to nibbles 0,2,1,3
   task automatic t_ticks();
      int pn[4] = '{0, 2, 1, 3};
      wr(ADDR_PRESCALER, 16'h3210);
      for (int p = 0; p < 4; p++) begin
         wr(ADDR_CH0_MODE, 16'(p) << 14);
         run(64, 0);
         chk("ticks", 16'(ticks), 16'(64 >> pn[p]));
      end
      wr(ADDR_PRESCALER, 16'h0005);
      wr(ADDR_CH0_MODE, 16'h0000);
      run(64, 0);
      chk("ticks", 16'(ticks), 16'h0002);
      wr(ADDR_CLOCK_EN, 16'h0000);
      run(64, 0);
      chk("ticks_gated", 16'(ticks), 16'h0000);
      // unclocked but out of reset: mode write still refused
      wr(ADDR_CH0_MODE, 16'h0800);
      rd(ADDR_CH0_MODE, 16'h0000);
      wr(ADDR_CLOCK_EN, 16'h0001);
   endtask
   // four rising and four falling pin edges per run
   task automatic t_pin();
      for (int e = 0; e < 4; e++) begin
         wr(ADDR_CH0_MODE, 16'h1000 | 16'(e) << 6);
         run(48, 6);
         chk("pin_ticks", 16'(ticks), (e < 2) ? 16'h0004 : 16'h0008);
      end
   endtask
   task automatic t_start();
      wr(ADDR_CH0_MODE, 16'h0000);
      wr(ADDR_CH0_TRIGGER, 16'h0001);
      // start pulse stands only in the cycle after the write
      @(negedge i_clock);
      chk("sw_start", 16'(o_start), 16'h0001);
      run(3, 0);
      chk("sw_start_len", 16'(starts), 16'h0000);
      run(48, 6);
      chk("pin_start", 16'(starts), 16'h0000);
      wr(ADDR_CH0_MODE, 16'h0140);
      run(48, 6);
      chk("pin_start", 16'(starts), 16'h0004);
      wr(ADDR_CH0_MODE, 16'h02C0);
      run(48, 6);
      chk("both_start", 16'(starts), 16'h0008);
      // unit reset mid-run: ticks stop, prescaler and mode cleared
      wr(ADDR_RESET_CTRL, 16'h0001);
      run(8, 0);
      chk("ticks_in_reset", 16'(ticks), 16'h0000);
      rd(ADDR_CH0_MODE, 16'h0000);
      rd(ADDR_PRESCALER, 16'h0000);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge i_clock);
      i_nrst <= 1'b1;
      t_reset_state();
      t_setup();
      t_modes();
      t_ticks();
      t_pin();
      t_start();
      test_done();
   end
endmodule
`default_nettype wire
